// *** src/fsp_pkg.sv ***
/*
 Package for the flash status-protect and identification-read block:
 opcodes, status bit positions, identification addresses and reset values.
 Assumes nothing of its surroundings.
*/
package fsp_pkg;
    // Opcodes
    localparam logic [7:0] OP_STATUS_WRITE_ARM = 8'h50;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_ID_READ_A = 8'h90;
    localparam logic [7:0] OP_ID_READ_B = 8'hab;
    // Status register bit positions
    localparam int unsigned SR_BLOCK_PROTECT_LO = 2;
    localparam int unsigned SR_BLOCK_PROTECT_HI = 3;
    localparam int unsigned SR_PROTECT_LOCK = 7;
    localparam logic [7:0] SR_PROTECT_MASK = 8'h8c;
    localparam logic [7:0] SR_RESET = 8'h0c;
    // Identification
    localparam logic [23:0] ID_ADDR_MFR = 24'h000000;
    localparam logic [23:0] ID_ADDR_DEV = 24'h000001;
    localparam int unsigned ADDR_BITS = 24;
    localparam int unsigned BYTE_BITS = 8;
    // Command states
    typedef enum logic [2:0] {
        FSP_OPCODE,
        FSP_ID_ADDR,
        FSP_ID_OUT,
        FSP_SR_DATA,
        FSP_IGNORE
    } fsp_state_t;
endpackage : fsp_pkg

// *** src/fsp_pin_sync.sv ***
/*
 Three-stage synchroniser for asynchronous pins; a change is accepted
 once the second and third stages agree.
 Assumes a free-running sampling clock much faster than the pins.
*/
`timescale 1ns/1ps
`default_nettype none
module fsp_pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;
    logic [WIDTH-1:0] level_d;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            assign level_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : level_q[g];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s1_q <= INIT;
            s2_q <= INIT;
            s3_q <= INIT;
            level_q <= INIT;
        end else if (ce_i) begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;
endmodule : fsp_pin_sync
`default_nettype wire

// *** src/fsp_flash_cmd.sv ***
/*
 Serial command handler for status-register protection writes and the
 identification read of a small serial flash.
 Assumes an SPI mode 0/3 host on chip select, serial clock and serial input;
 all pins are sampled by ref_clk_i, which must run well above the serial clock.
*/
// Operation
// RULE1 - Status write touches only protection bits
// RULE2 - Host sends status write right after arming
// RULE3 - Ignore status write when pin low, locked
// RULE4 - Pin low: lock bit only sets, never clears
// RULE5 - Pin high: lock and protect bits writable
// RULE6 - Gate checked at chip select rising edge
// RULE7 - One write sets lock and protect bits
// RULE8 - Host frames command with chip select
// RULE9 - Opcodes 90h or abh, then 24 address bits
// RULE10 - Address 0 manufacturer, address 1 device code
// RULE11 - Codes alternate until chip select rises
// RULE12 - Arming alone does nothing, lapses otherwise
// RULE13 - Bytes shifted most significant bit first
// RULE14 - One data byte follows status write opcode
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_cmd
    import fsp_pkg::*;
#(
    parameter logic [7:0] MFR_CODE = 8'h5a, // Arbitrary value
    parameter logic [7:0] DEV_CODE = 8'ha5  // Arbitrary value
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_clk_i,
    input wire logic serial_in_i,
    input wire logic write_protect_n_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic [7:0] status_o
);
    import fsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [3:0] pins;
    logic sel_n;
    logic sclk;
    logic sdi;
    logic wp_n;

    // Reset to idle pin levels (select high, clock high) so no false edge follows reset
    fsp_pin_sync #(
        .WIDTH(4),
        .INIT(4'hd)
    ) u_sync (
        .clk_i(ref_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .pin_i({chip_sel_n_i, serial_clk_i, serial_in_i, write_protect_n_i}),
        .level_o(pins)
    );
    assign sel_n = pins[3];
    assign sclk = pins[2];
    assign sdi = pins[1];
    assign wp_n = pins[0];

    ////////////////////////////////////////////////////////////////////////
    // Edge detection
    logic sclk_q;
    logic sel_n_q;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;

    assign sclk_rise = sclk & ~sclk_q & ~sel_n;
    assign sclk_fall = ~sclk & sclk_q & ~sel_n;
    assign frame_start = ~sel_n & sel_n_q;
    assign frame_end = sel_n & ~sel_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Command state
    fsp_state_t state_q;
    fsp_state_t state_d;
    logic [4:0] bit_cnt_q;
    logic [4:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] shift_next;
    logic byte_done;
    logic addr_done;
    logic [23:0] addr_q;
    logic [23:0] addr_d;
    logic armed_q;
    logic armed_d;
    logic wr_pending_q;
    logic wr_pending_d;
    logic [7:0] new_status_q;
    logic [7:0] new_status_d;
    logic [7:0] status_q;
    logic [7:0] status_d;
    logic [7:0] out_byte_q;
    logic [7:0] out_byte_d;
    logic [7:0] id_byte;
    logic sdo_q;
    logic sdo_d;
    logic sdo_oe_q;
    logic sdo_oe_d;
    logic is_id_op;
    logic write_allowed;
    logic [7:0] status_written;

    function automatic logic [7:0] id_code(input logic [23:0] addr, input logic [7:0] mfr, input logic [7:0] dev);
        id_code = (addr[0] == ID_ADDR_DEV[0]) ? dev : mfr; // RULE10
    endfunction : id_code

    assign shift_next = {shift_q[6:0], sdi}; // RULE13
    assign byte_done = sclk_rise && (bit_cnt_q == 5'(BYTE_BITS - 1));
    assign addr_done = sclk_rise && (bit_cnt_q == 5'(ADDR_BITS - 1));
    assign is_id_op = (shift_next == OP_ID_READ_A) || (shift_next == OP_ID_READ_B); // RULE9
    assign id_byte = id_code(addr_q, MFR_CODE, DEV_CODE);

    // Locked only when pin low and lock bit set; lock may still be set from 0
    assign write_allowed = wp_n || !status_q[SR_PROTECT_LOCK]; // RULE3 RULE4 RULE5 RULE6
    assign status_written = (status_q & ~SR_PROTECT_MASK) | (new_status_q & SR_PROTECT_MASK); // RULE1 RULE7

    always_comb begin
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        addr_d = addr_q;
        armed_d = armed_q;
        wr_pending_d = wr_pending_q;
        new_status_d = new_status_q;
        status_d = status_q;
        out_byte_d = out_byte_q;
        sdo_d = sdo_q;
        sdo_oe_d = sdo_oe_q;
        if (sclk_rise) begin
            shift_d = shift_next;
            bit_cnt_d = bit_cnt_q + 5'h01;
        end
        case (state_q)
            FSP_OPCODE: begin
                if (byte_done) begin
                    bit_cnt_d = '0;
                    // Any opcode consumes the arming, only the write uses it
                    armed_d = 1'b0; // RULE12
                    if (is_id_op) begin
                        state_d = FSP_ID_ADDR;
                    end else if (shift_next == OP_STATUS_WRITE && armed_q) begin // RULE2
                        state_d = FSP_SR_DATA; // RULE14
                    end else begin
                        armed_d = (shift_next == OP_STATUS_WRITE_ARM); // RULE12
                        state_d = FSP_IGNORE;
                    end
                end
            end
            FSP_ID_ADDR: begin
                if (sclk_rise) begin
                    addr_d = {addr_q[22:0], sdi};
                end
                if (addr_done) begin
                    bit_cnt_d = '0;
                    state_d = FSP_ID_OUT;
                    out_byte_d = id_code({addr_q[22:0], sdi}, MFR_CODE, DEV_CODE);
                end
            end
            FSP_ID_OUT: begin
                // Drive on falling edge, msb first
                if (sclk_fall) begin
                    sdo_oe_d = 1'b1;
                    sdo_d = out_byte_q[7]; // RULE13
                    out_byte_d = {out_byte_q[6:0], 1'b0};
                end
                if (byte_done) begin
                    bit_cnt_d = '0;
                    addr_d = addr_q ^ ID_ADDR_DEV; // RULE11
                    out_byte_d = id_code(addr_q ^ ID_ADDR_DEV, MFR_CODE, DEV_CODE); // RULE11
                end
            end
            FSP_SR_DATA: begin
                if (byte_done) begin
                    new_status_d = shift_next; // RULE14
                    wr_pending_d = 1'b1;
                    state_d = FSP_IGNORE;
                end
            end
            FSP_IGNORE: begin
            end
            default: state_d = FSP_IGNORE;
        endcase
        if (frame_end) begin
            // Write executes only on chip select rising edge
            if (wr_pending_q && write_allowed) begin // RULE6 RULE8
                status_d = status_written;
            end
            wr_pending_d = 1'b0;
            state_d = FSP_OPCODE;
            sdo_oe_d = 1'b0;
            sdo_d = 1'b0;
        end
        if (frame_start) begin
            state_d = FSP_OPCODE;
            bit_cnt_d = '0;
            addr_d = '0;
            wr_pending_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            sclk_q <= 1'b1;
            sel_n_q <= 1'b1;
            state_q <= FSP_OPCODE;
            bit_cnt_q <= '0;
            shift_q <= '0;
            addr_q <= '0;
            armed_q <= 1'b0;
            wr_pending_q <= 1'b0;
            new_status_q <= '0;
            status_q <= SR_RESET;
            out_byte_q <= '0;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
        end else if (ce_i) begin
            sclk_q <= sclk;
            sel_n_q <= sel_n;
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            addr_q <= addr_d;
            armed_q <= armed_d;
            wr_pending_q <= wr_pending_d;
            new_status_q <= new_status_d;
            status_q <= status_d;
            out_byte_q <= out_byte_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
        end
    end

    assign serial_out_o = sdo_q;
    assign serial_out_oe_o = sdo_oe_q;
    assign status_o = status_q;
endmodule : fsp_flash_cmd
`default_nettype wire

// *** bench/fsp_cmd_properties.sv ***
/* Port checker for fsp_flash_cmd.
 Assumes pins reach the logic a few ref_clk_i cycles late. */
`timescale 1ns/1ps
`default_nettype none
module fsp_cmd_properties (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic chip_sel_n_i,
    input wire logic serial_clk_i,
    input wire logic write_protect_n_i,
    input wire logic serial_out_o,
    input wire logic serial_out_oe_o,
    input wire logic [7:0] status_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    ////////////////////////////////
    property p_fixed; $changed(status_o) |-> ((status_o ^ $past(status_o)) & 8'h73) == 8'h00; endproperty
    a_fixed: assert property (p_fixed) else $error("Unprotected status bit moved");
    property p_locked; !write_protect_n_i [*8] ##0 status_o[7] |=> $stable(status_o); endproperty
    a_locked: assert property (p_locked) else $error("Locked status changed");
    property p_cs_low; !chip_sel_n_i [*8] |-> $stable(status_o); endproperty
    a_cs_low: assert property (p_cs_low) else $error("Status moved inside a frame");
    property p_after_cs; $changed(status_o) |-> $past(chip_sel_n_i, 2); endproperty
    a_after_cs: assert property (p_after_cs) else $error("Status moved before select rose");
    property p_oe_rise; $rose(serial_out_oe_o) |-> !chip_sel_n_i && !serial_clk_i; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("Output enabled outside a read");
    property p_oe_fall; $fell(serial_out_oe_o) |-> chip_sel_n_i; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("Output dropped inside a read");
    property p_oe_idle; chip_sel_n_i [*8] |-> !serial_out_oe_o; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("Output driven while deselected");
    property p_shift; $changed(serial_out_o) && serial_out_oe_o |-> !serial_clk_i; endproperty
    a_shift: assert property (p_shift) else $error("Output moved while clock high");
    c_lock_set: cover property ($rose(status_o[7]));
    c_lock_clr: cover property ($fell(status_o[7]));
    c_id_out: cover property ($rose(serial_out_oe_o));
endmodule : fsp_cmd_properties
bind fsp_flash_cmd fsp_cmd_properties u_fsp_cmd_properties (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .chip_sel_n_i(chip_sel_n_i), .serial_clk_i(serial_clk_i), .write_protect_n_i(write_protect_n_i),
    .serial_out_o(serial_out_o), .serial_out_oe_o(serial_out_oe_o), .status_o(status_o));
`default_nettype wire

// *** bench/fsp_spi_host.sv ***
/* Serial host model, clock idles high, 125 ns period.
 Assumes the bench calls frame() and watches rx_tgl_o. */
`timescale 1ns/1ps
`default_nettype none
module fsp_spi_host (
    output logic cs_n_o,
    output logic sclk_o,
    output logic sdi_o,
    input wire logic sdo_i,
    input wire logic sdo_oe_i,
    output logic [7:0] rx_byte_o,
    output logic rx_tgl_o
);
    localparam realtime HALF = 62.5;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b1;
        sdi_o = 1'b0;
        rx_byte_o = 8'h00;
        rx_tgl_o = 1'b0;
    end
    // Undriven output reads as unknown so it never matches
    task automatic frame(input logic [31:0] tx, input int n, input int nrd);
        cs_n_o = 1'b0;
        #HALF;
        for (int i = 0; i < n + nrd; i++) begin
            sclk_o = 1'b0;
            sdi_o = (i < n) ? tx[31 - i] : ~sdi_o;
            #HALF;
            sclk_o = 1'b1;
            if (i >= n) begin
                rx_byte_o = {rx_byte_o[6:0], sdo_oe_i ? sdo_i : 1'bx};
                if ((i - n) % 8 == 7) begin
                    rx_tgl_o = ~rx_tgl_o;
                end
            end
            #HALF;
        end
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o;
        #(4 * HALF);
    endtask : frame
endmodule : fsp_spi_host
`default_nettype wire

// *** bench/testbench.sv ***
/* Self-checking bench for status protection writes and id reads.
 Assumes fsp_spi_host as serial master and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import fsp_pkg::*;
    localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
    localparam logic [7:0] DEV = 8'hc3; // Arbitrary value
    logic ref_clk, reset, ce, wp_n, cs_n, sclk, sdi, sdo, sdo_oe, rx_tgl;
    logic [7:0] status, rx_byte, sr;
    logic [8:0] rnd;
    logic [7:0] exp_q[$];
    int err_count = 0;
    int num_checks = 0;
    int cycles = 0;
    fsp_flash_cmd #(.MFR_CODE(MFR), .DEV_CODE(DEV)) u_fsp_flash_cmd (.ref_clk_i(ref_clk), .reset_i(reset),
        .ce_i(ce), .chip_sel_n_i(cs_n), .serial_clk_i(sclk), .serial_in_i(sdi), .write_protect_n_i(wp_n),
        .serial_out_o(sdo), .serial_out_oe_o(sdo_oe), .status_o(status));
    fsp_spi_host u_fsp_spi_host (.cs_n_o(cs_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .rx_byte_o(rx_byte), .rx_tgl_o(rx_tgl));
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("Checks %0d, errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////
    task automatic idr(input logic [7:0] op, input logic a0);
        for (int i = 0; i < 5; i++) begin
            exp_q.push_back((a0 ^ i[0]) ? DEV : MFR);
        end
        u_fsp_spi_host.frame({op, 23'h0, a0}, 32, 40);
    endtask : idr
    task automatic wr(input logic wp, input logic [7:0] d);
        @(posedge ref_clk);
        wp_n <= wp;
        u_fsp_spi_host.frame({OP_STATUS_WRITE_ARM, 24'h0}, 8, 0);
        u_fsp_spi_host.frame({OP_STATUS_WRITE, d, 16'h0}, 16, 0);
        if (wp || !sr[7]) sr = (sr & ~SR_PROTECT_MASK) | (d & SR_PROTECT_MASK);
        chk(status, sr);
    endtask : wr
    // Late start skips the time-zero toggle of the host
    initial begin
        #1;
        forever begin
            @(rx_tgl);
            chk(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);
        end
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            stop_test();
        end
    end
    initial begin
        reset = 1'b1;
        ce = 1'b1;
        wp_n = 1'b1;
        sr = SR_RESET;
        rnd = 9'h000;
        void'($urandom(32'h6d12));
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk(status, SR_RESET);
        idr(OP_ID_READ_A, 1'b0);
        idr(OP_ID_READ_B, 1'b1);
        u_fsp_spi_host.frame({OP_STATUS_WRITE, 8'h80, 16'h0}, 16, 0);
        chk(status, sr);
        u_fsp_spi_host.frame({OP_STATUS_WRITE_ARM, 24'h0}, 8, 0);
        idr(OP_ID_READ_A, 1'b1);
        u_fsp_spi_host.frame({OP_STATUS_WRITE, 8'h80, 16'h0}, 16, 0);
        chk(status, sr);
        u_fsp_spi_host.frame({OP_STATUS_WRITE_ARM, 24'h0}, 8, 0);
        u_fsp_spi_host.frame({OP_STATUS_WRITE, 8'h80, 16'h0}, 12, 0);
        chk(status, sr);
        wr(1'b1, 8'h04);
        wr(1'b0, 8'h88);
        wr(1'b0, 8'h00);
        wr(1'b1, 8'h00);
        for (int i = 0; i < 10; i++) begin
            rnd = 9'($urandom);
            wr(rnd[8], rnd[7:0]);
        end
        // Frozen block must miss a full arm and write sequence
        @(posedge ref_clk);
        wp_n <= 1'b1;
        ce <= 1'b0;
        u_fsp_spi_host.frame({OP_STATUS_WRITE_ARM, 24'h0}, 8, 0);
        u_fsp_spi_host.frame({OP_STATUS_WRITE, ~sr, 16'h0}, 16, 0);
        chk(status, sr);
        @(posedge ref_clk);
        ce <= 1'b1;
        wr(1'b1, 8'h8c);
        chk(8'(exp_q.size()), 8'h00);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
